// file: hdl/adc_seq_pkg.sv
package adc_seq_pkg;
  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_CHAN = 4'h1;
  localparam logic [3:0] ADDR_PRIO = 4'h2;
  localparam logic [3:0] ADDR_RESET = 4'h3;
  localparam logic [3:0] ADDR_TRIG = 4'h4;
  localparam logic [3:0] ADDR_RES0 = 4'h8;
  localparam logic [3:0] ADDR_RESP = 4'h7;
  // Mode control register fields.
  localparam int MODE_START_BIT = 0;
  localparam int MODE_SCAN_BIT = 1;
  localparam int MODE_REPEAT_BIT = 2;
  localparam int MODE_ITM_LSB = 3;
  localparam int MODE_BUSY_BIT = 6;
  localparam int MODE_DONE_BIT = 7;
  // Priority control register fields.
  localparam int PRIO_START_BIT = 4;
  localparam int PRIO_BUSY_BIT = 5;
  localparam int PRIO_DONE_BIT = 6;
  // Trigger control and reset register fields.
  localparam int TRIG_NSRC_BIT = 0;
  localparam int TRIG_NEN_BIT = 1;
  localparam int TRIG_PSRC_BIT = 2;
  localparam int TRIG_PEN_BIT = 3;
  localparam int RESET_BIT = 0;
  // Result word fields, interval codes and mode codes.
  localparam int RES_STORED_BIT = 10;
  localparam int RES_OVR_BIT = 11;
  localparam logic [1:0] ITM_ONE = 2'h0;
  localparam logic [1:0] ITM_FOUR = 2'h1;
  localparam logic [1:0] ITM_EIGHT = 2'h2;
  localparam logic [1:0] MODE_FIX_SINGLE = 2'h0;
  localparam logic [1:0] MODE_SCAN_SINGLE = 2'h1;
  localparam logic [1:0] MODE_FIX_REPEAT = 2'h2;
  localparam logic [1:0] MODE_SCAN_REPEAT = 2'h3;

  typedef enum {ST_IDLE, ST_NORM, ST_PRIO} phase_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic start;
    logic [3:0] chan;
    logic done;
    logic [9:0] value;
  } core_t;
endpackage

// file: hdl/adc_conversion_sequencer.sv
`timescale 1ns/1ns
// Behaviour
// - Writing one to the normal start bit begins a normal sequence in the selected mode.
// - Writing one to the priority start bit begins one fixed-channel priority conversion.
// - Source select zero: falling edge on the external trigger pin starts conversion.
// - Source select one: timer 6 event starts normal, timer 5 event starts priority.
// - Hardware triggers are accepted only while their enable bit is one.
// - Software starts still work while hardware triggering is enabled.
// - Normal busy flag is set when a normal sequence starts.
// - Priority start sets priority busy and keeps normal busy and done unchanged.
// - Priority start suspends normal sequence, which resumes at the interrupted channel.
// - Clearing repeat finishes the current conversion, then stops and clears busy.
// - Outside fixed repeat, each result goes to the result register picked by the low three bits of its channel.
// - Fixed single: on completion set done, clear busy, raise normal interrupt.
// - Scan single: after whole scan set done, clear busy, raise normal interrupt.
// - Fixed repeat keeps busy high; done is set together with the interrupt.
// - Interval 00: interrupt every conversion, result always in first register.
// - Interval 01: rotate over four registers, interrupt after fourth, wrap.
// - Interval 10: rotate over eight registers, interrupt after eighth, wrap.
// - Scan repeat: done and interrupt per scan, busy stays, per-channel results.
// - Priority completion raises its interrupt, sets its done flag, stores its result.
// - Reading the mode or priority register clears its done flag.
// - Mode codes: 00 fixed single, 01 scan single, 10 fixed repeat, 11 scan repeat.
// - A priority start during a running priority conversion is ignored.
module adc_conversion_sequencer #(
  parameter int NUM_RESULTS = 8
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Trigger sources
  input wire logic EXT_TRIGGER_N,
  input wire logic TIMER6_COMPARE_EVENT,
  input wire logic TIMER5_COMPARE_EVENT,
  // Analog core
  output logic CORE_START,
  output logic [3:0] CORE_CHAN,
  input wire logic CORE_DONE,
  input wire logic [9:0] CORE_VALUE,
  // Completion interrupts
  output logic NORMAL_DONE_INTERRUPT,
  output logic PRIORITY_DONE_INTERRUPT
);

  typedef struct packed {
    adc_seq_pkg::phase_t phase;
    logic conv_run;
    logic [1:0] mode;
    logic [1:0] itm;
    logic [3:0] chan_sel;
    logic [3:0] scan_last;
    logic [3:0] prio_chan;
    logic [3:0] trig;
    logic norm_busy;
    logic norm_done;
    logic prio_busy;
    logic prio_done;
    logic [3:0] cur_chan;
    logic [2:0] slot;
    logic [2:0] pin_sync;
    logic core_start;
    logic norm_irq;
    logic prio_irq;
    logic [15:0] rdata;
    logic [NUM_RESULTS-1:0][9:0] res;
    logic [NUM_RESULTS-1:0] stored;
    logic [NUM_RESULTS-1:0] ovr;
    logic [9:0] resp;
    logic resp_stored;
    logic resp_ovr;
    logic stop_pending;
  } state_t;

  state_t s;
  state_t next_s;
  logic pin_fall;
  logic norm_hw;
  logic prio_hw;
  logic sw_norm;
  logic sw_prio;
  logic norm_go;
  logic prio_go;
  logic [2:0] store_idx;
  logic last_of_group;
  logic soft_reset;

  function automatic logic [2:0] slot_limit(input logic [1:0] itm);
    slot_limit = (itm == adc_seq_pkg::ITM_EIGHT) ? 3'h7 : (itm == adc_seq_pkg::ITM_FOUR) ? 3'h3 : 3'h0;
  endfunction

  // Only the second and third sync stages feed the edge detector.
  assign pin_fall = s.pin_sync[2] & ~s.pin_sync[1];
  assign norm_hw = s.trig[adc_seq_pkg::TRIG_NEN_BIT] &
    (s.trig[adc_seq_pkg::TRIG_NSRC_BIT] ? TIMER6_COMPARE_EVENT : pin_fall);
  assign prio_hw = s.trig[adc_seq_pkg::TRIG_PEN_BIT] &
    (s.trig[adc_seq_pkg::TRIG_PSRC_BIT] ? TIMER5_COMPARE_EVENT : pin_fall);
  assign sw_norm = WR && ADDR == adc_seq_pkg::ADDR_MODE && WDATA[adc_seq_pkg::MODE_START_BIT];
  assign sw_prio = WR && ADDR == adc_seq_pkg::ADDR_PRIO && WDATA[adc_seq_pkg::PRIO_START_BIT];
  assign norm_go = (sw_norm | norm_hw) & ~s.prio_busy;
  assign prio_go = (sw_prio | prio_hw) & ~s.prio_busy;
  assign store_idx = s.mode == adc_seq_pkg::MODE_FIX_REPEAT ? s.slot : s.cur_chan[2:0];
  assign last_of_group = s.mode[0] ? (s.cur_chan == s.scan_last) : (s.slot == slot_limit(s.itm));
  assign soft_reset = WR && ADDR == adc_seq_pkg::ADDR_RESET && WDATA[adc_seq_pkg::RESET_BIT];

  assign RDATA = s.rdata;
  assign CORE_START = s.core_start;
  assign CORE_CHAN = s.phase == adc_seq_pkg::ST_PRIO ? s.prio_chan : s.cur_chan;
  assign NORMAL_DONE_INTERRUPT = s.norm_irq;
  assign PRIORITY_DONE_INTERRUPT = s.prio_irq;

  always_comb begin
    next_s = s;
    next_s.pin_sync = {s.pin_sync[1:0], EXT_TRIGGER_N};
    next_s.core_start = 1'b0;
    next_s.norm_irq = 1'b0;
    next_s.prio_irq = 1'b0;
    next_s.rdata = 16'h0000;
    // Register reads; done flags clear on read, but a same-cycle set below wins.
    if (RD) begin
      unique case (ADDR)
        adc_seq_pkg::ADDR_MODE: begin
          next_s.rdata = {8'h00, s.norm_done, s.norm_busy, 1'b0, s.itm, s.mode[1], s.mode[0], 1'b0};
          next_s.norm_done = 1'b0;
        end
        adc_seq_pkg::ADDR_CHAN: next_s.rdata = {8'h00, s.scan_last, s.chan_sel};
        adc_seq_pkg::ADDR_PRIO: begin
          next_s.rdata = {9'h000, s.prio_done, s.prio_busy, 1'b0, s.prio_chan};
          next_s.prio_done = 1'b0;
        end
        adc_seq_pkg::ADDR_TRIG: next_s.rdata = {12'h000, s.trig};
        adc_seq_pkg::ADDR_RESP: begin
          next_s.rdata = {4'h0, s.resp_ovr, s.resp_stored, s.resp};
          next_s.resp_stored = 1'b0;
          next_s.resp_ovr = 1'b0;
        end
        default: begin
          if (ADDR >= adc_seq_pkg::ADDR_RES0) begin
            next_s.rdata = {4'h0, s.ovr[ADDR[2:0]], s.stored[ADDR[2:0]], s.res[ADDR[2:0]]};
            next_s.stored[ADDR[2:0]] = 1'b0;
            next_s.ovr[ADDR[2:0]] = 1'b0;
          end
        end
      endcase
    end
    if (WR) begin
      unique case (ADDR)
        adc_seq_pkg::ADDR_MODE: begin
          next_s.mode = {WDATA[adc_seq_pkg::MODE_REPEAT_BIT], WDATA[adc_seq_pkg::MODE_SCAN_BIT]};
          next_s.itm = WDATA[adc_seq_pkg::MODE_ITM_LSB +: 2];
          // Dropping the repeat bit only arms the stop; the conversion in flight still finishes.
          next_s.stop_pending = (s.stop_pending | (s.mode[1] & s.norm_busy)) & ~WDATA[adc_seq_pkg::MODE_REPEAT_BIT];
        end
        adc_seq_pkg::ADDR_CHAN: begin
          next_s.chan_sel = WDATA[3:0];
          next_s.scan_last = WDATA[7:4];
        end
        adc_seq_pkg::ADDR_PRIO: next_s.prio_chan = WDATA[3:0];
        adc_seq_pkg::ADDR_TRIG: next_s.trig = WDATA[3:0];
        default: begin
        end
      endcase
    end
    // Core completion.
    if (CORE_DONE && s.conv_run) begin
      next_s.conv_run = 1'b0;
      if (s.phase == adc_seq_pkg::ST_PRIO) begin
        if (next_s.resp_stored) begin
          next_s.resp_ovr = 1'b1;
        end
        next_s.resp = CORE_VALUE;
        next_s.resp_stored = 1'b1;
        next_s.prio_done = 1'b1;
        next_s.prio_irq = 1'b1;
        next_s.prio_busy = 1'b0;
        // Resume the suspended sequence at the same channel.
        next_s.phase = s.norm_busy ? adc_seq_pkg::ST_NORM : adc_seq_pkg::ST_IDLE;
      end else begin
        if (next_s.stored[store_idx]) begin
          next_s.ovr[store_idx] = 1'b1;
        end
        next_s.res[store_idx] = CORE_VALUE;
        next_s.stored[store_idx] = 1'b1;
        if (s.mode == adc_seq_pkg::MODE_FIX_REPEAT) begin
          next_s.slot = last_of_group ? 3'h0 : s.slot + 3'h1;
        end else if (s.mode[0]) begin
          next_s.cur_chan = last_of_group ? s.chan_sel : s.cur_chan + 4'h1;
        end
        if (last_of_group || s.mode == adc_seq_pkg::MODE_FIX_SINGLE) begin
          next_s.norm_done = 1'b1;
          next_s.norm_irq = 1'b1;
        end
        if (!s.mode[1] && (last_of_group || !s.mode[0])) begin
          next_s.norm_busy = 1'b0;
          next_s.phase = adc_seq_pkg::ST_IDLE;
        end
        // A pending stop ends the run after this conversion, even in the middle of a scan.
        if (s.stop_pending) begin
          next_s.norm_busy = 1'b0;
          next_s.phase = adc_seq_pkg::ST_IDLE;
          next_s.stop_pending = 1'b0;
        end
      end
    end
    // Priority pre-empts; the interrupted normal conversion is simply re-run later.
    if (prio_go) begin
      next_s.phase = adc_seq_pkg::ST_PRIO;
      next_s.prio_busy = 1'b1;
      next_s.conv_run = 1'b0;
    end else if (norm_go && s.phase == adc_seq_pkg::ST_IDLE) begin
      next_s.phase = adc_seq_pkg::ST_NORM;
      next_s.norm_busy = 1'b1;
      next_s.cur_chan = s.chan_sel;
      next_s.slot = 3'h0;
    end
    if (next_s.phase != adc_seq_pkg::ST_IDLE && !next_s.conv_run && !s.core_start) begin
      next_s.core_start = 1'b1;
      next_s.conv_run = 1'b1;
    end
    // Soft reset stops everything but keeps results and done flags.
    if (soft_reset) begin
      next_s.phase = adc_seq_pkg::ST_IDLE;
      next_s.stop_pending = 1'b0;
      next_s.conv_run = 1'b0;
      next_s.core_start = 1'b0;
      next_s.norm_busy = 1'b0;
      next_s.prio_busy = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s <= '0;
      s.phase <= adc_seq_pkg::ST_IDLE;
      s.pin_sync <= 3'h7;
    end else begin
      s <= next_s;
    end
  end

  sequence prio_started_s;
    prio_go;
  endsequence

  sequence prio_finished_s;
    CORE_DONE && s.phase == adc_seq_pkg::ST_PRIO && s.conv_run;
  endsequence

  // Register writes are kept out so that a mode change or soft reset cannot blur the check.
  sequence norm_finished_s;
    CORE_DONE && s.phase == adc_seq_pkg::ST_NORM && s.conv_run && !prio_go && !WR;
  endsequence

  // The start may slip one cycle when a normal start pulse is still on the wire.
  sequence prio_launch_s;
    ##[1:2] (CORE_START && s.phase == adc_seq_pkg::ST_PRIO);
  endsequence

  norm_busy_set_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    norm_go && !prio_go && s.phase == adc_seq_pkg::ST_IDLE |=> s.norm_busy)
    else $error("normal busy not set on start");
  prio_busy_set_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    prio_started_s |=> s.prio_busy && s.norm_busy == $past(s.norm_busy))
    else $error("priority start corrupted busy flags");
  prio_done_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (prio_finished_s and !prio_go) |=> PRIORITY_DONE_INTERRUPT && s.prio_done && !s.prio_busy)
    else $error("priority completion not flagged");
  prio_ignore_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    s.prio_busy |-> !prio_go)
    else $error("priority start accepted while busy");
  norm_block_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    s.prio_busy |-> !norm_go)
    else $error("normal start accepted during priority");
  resume_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (prio_finished_s and s.norm_busy && !prio_go) |=> s.phase == adc_seq_pkg::ST_NORM && CORE_START)
    else $error("normal sequence not resumed");
  prio_launch_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (prio_started_s and !soft_reset) |-> prio_launch_s)
    else $error("priority conversion not launched");
  fix_single_done_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (norm_finished_s and s.mode == adc_seq_pkg::MODE_FIX_SINGLE) |=>
      NORMAL_DONE_INTERRUPT && s.norm_done && !s.norm_busy)
    else $error("fixed single completion not flagged");
  scan_single_done_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (norm_finished_s and s.mode == adc_seq_pkg::MODE_SCAN_SINGLE && s.cur_chan == s.scan_last) |=>
      NORMAL_DONE_INTERRUPT && s.norm_done && !s.norm_busy)
    else $error("scan single completion not flagged");
  stop_repeat_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (norm_finished_s and s.stop_pending) |=> !s.norm_busy && s.phase == adc_seq_pkg::ST_IDLE)
    else $error("repeat not stopped after conversion");
  slot_wrap_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    (norm_finished_s and s.mode == adc_seq_pkg::MODE_FIX_REPEAT && s.slot == slot_limit(s.itm)) |=>
      s.slot == 3'h0)
    else $error("result slot did not wrap");
  scan_repeat_busy_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    s.mode == adc_seq_pkg::MODE_SCAN_REPEAT && s.norm_busy && !WR |=> s.norm_busy)
    else $error("busy dropped in scan repeat");
  norm_hw_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    s.phase == adc_seq_pkg::ST_IDLE && !s.norm_busy && !sw_norm && !prio_go &&
      !s.trig[adc_seq_pkg::TRIG_NEN_BIT] |=> !s.norm_busy)
    else $error("normal start without enable");
  prio_hw_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !s.prio_busy && !sw_prio && !s.trig[adc_seq_pkg::TRIG_PEN_BIT] |=> !s.prio_busy)
    else $error("priority start without enable");
  timer_norm_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    TIMER6_COMPARE_EVENT && s.trig[adc_seq_pkg::TRIG_NEN_BIT] && s.trig[adc_seq_pkg::TRIG_NSRC_BIT] &&
      s.phase == adc_seq_pkg::ST_IDLE && !s.prio_busy && !prio_go && !soft_reset |=> s.norm_busy)
    else $error("timer event did not start normal conversion");
  timer_prio_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    TIMER5_COMPARE_EVENT && s.trig[adc_seq_pkg::TRIG_PEN_BIT] && s.trig[adc_seq_pkg::TRIG_PSRC_BIT] &&
      !s.prio_busy && !soft_reset |=> s.prio_busy)
    else $error("timer event did not start priority conversion");
  fix_repeat_busy_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    s.mode == adc_seq_pkg::MODE_FIX_REPEAT && s.norm_busy && !WR |=> s.norm_busy)
    else $error("busy dropped in fixed repeat");
  itm_one_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    s.mode == adc_seq_pkg::MODE_FIX_REPEAT && s.itm == adc_seq_pkg::ITM_ONE |-> store_idx == 3'h0)
    else $error("interval 00 must store in first register");
  done_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    RD && ADDR == adc_seq_pkg::ADDR_PRIO && !(CORE_DONE && s.conv_run) |=> !s.prio_done)
    else $error("priority done not cleared by read");
endmodule

// file: test/adc_core_model.sv
`timescale 1ns/1ns
// Analog core stand-in: a new start aborts the conversion in flight, as a pre-empting start needs.
module adc_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Sequencer side
  input wire logic slow,
  input wire logic start,
  input wire logic [3:0] chan,
  output logic done,
  output logic [9:0] value
);
  logic [4:0] left;
  logic [3:0] held;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      left <= 5'h00;
      held <= 4'h0;
      done <= 1'h0;
      value <= 10'h155;
    end else begin
      done <= 1'h0;
      // Between results the value toggles, so a stale sample never passes for a fresh one.
      value <= ~value;
      if (start) begin
        left <= slow ? 5'h0c : 5'h02;
        held <= chan;
      end else if (left != 5'h00) begin
        left <= left - 5'h01;
        if (left == 5'h01) begin
          done <= 1'h1;
          value <= {held, 6'h2d};
        end
      end
    end
  end
endmodule

// file: test/adc_conversion_sequencer_test.sv
`timescale 1ns/1ns
module test_adc_conversion_sequencer;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic ext_n = 1'h1;
  logic t6 = 1'h0;
  logic t5 = 1'h0;
  logic slow = 1'h1;
  logic [15:0] rdata;
  logic cstart, cdone, nirq, pirq;
  logic [3:0] cchan;
  logic [9:0] cval;
  logic [3:0] starts[$];
  logic [7:0] row_chan[4] = '{8'h33, 8'hcc, 8'h42, 8'h96};
  logic [15:0] rep_mode[4] = '{16'h0004, 16'h000c, 16'h0014, 16'h0006};
  logic [7:0] rep_mask[4] = '{8'h01, 8'h0f, 8'hff, 8'h03};
  logic [3:0] rep_n[4] = '{4'h1, 4'h4, 4'h8, 4'h2};
  logic [3:0] prio_seq[6] = '{4'h0, 4'h1, 4'h2, 4'h9, 4'h2, 4'h3};
  int irqs[2] = '{0, 0};
  int err_count = 0;
  int comparisons = 0;
  adc_conversion_sequencer adc_conversion_sequencer_inst (.CLK(clk), .SYS_RST(sys_rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .EXT_TRIGGER_N(ext_n), .TIMER6_COMPARE_EVENT(t6),
    .TIMER5_COMPARE_EVENT(t5), .CORE_START(cstart), .CORE_CHAN(cchan), .CORE_DONE(cdone), .CORE_VALUE(cval),
    .NORMAL_DONE_INTERRUPT(nirq), .PRIORITY_DONE_INTERRUPT(pirq));
  adc_core_model adc_core_model_inst (.clk(clk), .sys_rst(sys_rst), .slow(slow), .start(cstart),
    .chan(cchan), .done(cdone), .value(cval));
  always #10 clk = ~clk;
  // Starts and interrupt pulses are logged so order and pulse counts can be judged afterwards.
  always @(posedge clk) begin
    if (cstart === 1'h1) starts.push_back(cchan);
    if (nirq === 1'h1) irqs[0]++;
    if (pirq === 1'h1) irqs[1]++;
  end
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input string n, input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] d;
    rd_reg(a, d);
    check(n, e, d & m);
  endtask
  // Counts finished conversions up to the next completion interrupt; a missing interrupt ends the run.
  task automatic count_to(input logic p, output int n);
    n = 0;
    for (int i = 0; i < 600; i++) begin
      @(posedge clk);
      #1;
      if (cdone === 1'h1) n++;
      if ((p ? pirq : nirq) === 1'h1) return;
    end
    check("irq wait", 16'h0001, 16'h0000);
    tally_and_finish;
  endtask
  task automatic trig(input int k, input logic p, input logic e, input logic [3:0] ch);
    int b;
    b = irqs[p];
    starts.delete();
    @(posedge clk);
    case (k)
      0: ext_n <= 1'h0;
      1: t6 <= 1'h1;
      default: t5 <= 1'h1;
    endcase
    @(posedge clk);
    t6 <= 1'h0;
    t5 <= 1'h0;
    repeat (12) @(posedge clk);
    ext_n <= 1'h1;
    check("trig starts", 16'(e), 16'(starts.size()));
    check("trig irqs", 16'(e), 16'(irqs[p] - b));
    if (e) check("trig chan", 16'(ch), 16'(starts[0]));
  endtask
  initial begin
    logic [15:0] d;
    logic sc;
    int n;
    repeat (10) @(posedge clk);
    sys_rst <= 1'h0;
    for (int a = 0; a < 16; a++) rd_chk("reset value", 4'(a), 16'hffff, 16'h0000);
    wr_reg(adc_seq_pkg::ADDR_TRIG, 16'h0003);
    for (int r = 0; r < 4; r++) begin
      sc = row_chan[r][7:4] != row_chan[r][3:0];
      wr_reg(adc_seq_pkg::ADDR_CHAN, {8'h00, row_chan[r]});
      wr_reg(adc_seq_pkg::ADDR_MODE, {14'h0000, sc, 1'h1});
      rd_chk("busy", adc_seq_pkg::ADDR_MODE, 16'h00c0, 16'h0040);
      count_to(1'h0, n);
      check("scan length", 16'(row_chan[r][7:4] - row_chan[r][3:0] + 8'h01), 16'(n));
      rd_chk("done", adc_seq_pkg::ADDR_MODE, 16'h00c0, 16'h0080);
      rd_chk("done clear", adc_seq_pkg::ADDR_MODE, 16'h00c0, 16'h0000);
      for (int c = row_chan[r][3:0]; c <= row_chan[r][7:4]; c++)
        rd_chk("result", adc_seq_pkg::ADDR_RES0 | {1'h0, c[2:0]}, 16'h0fff, {6'h01, c[3:0], 6'h2d});
    end
    wr_reg(adc_seq_pkg::ADDR_CHAN, 16'h0010);
    for (int r = 0; r < 4; r++) begin
      wr_reg(adc_seq_pkg::ADDR_MODE, rep_mode[r] | 16'h0001);
      count_to(1'h0, n);
      check("per irq", 16'(rep_n[r]), 16'(n));
      rd_chk("repeat flags", adc_seq_pkg::ADDR_MODE, 16'h00c0, 16'h00c0);
      wr_reg(adc_seq_pkg::ADDR_MODE, rep_mode[r] & 16'hfffb);
      rd_chk("stop busy", adc_seq_pkg::ADDR_MODE, 16'h0040, 16'h0040);
      d = 16'h0040;
      for (int i = 0; i < 20 && d[6]; i++) rd_reg(adc_seq_pkg::ADDR_MODE, d);
      check("stopped", 16'h0000, d & 16'h0040);
      for (int c = 0; c < 8; c++)
        rd_chk("slot", adc_seq_pkg::ADDR_RES0 | 4'(c), 16'h0400, {5'h00, rep_mask[r][c], 10'h000});
    end
    wr_reg(adc_seq_pkg::ADDR_CHAN, 16'h0030);
    starts.delete();
    wr_reg(adc_seq_pkg::ADDR_MODE, 16'h0003);
    for (int i = 0; i < 100 && starts.size() < 3; i++) @(posedge clk);
    wr_reg(adc_seq_pkg::ADDR_PRIO, 16'h0019);
    wr_reg(adc_seq_pkg::ADDR_PRIO, 16'h0019);
    rd_chk("prio busy", adc_seq_pkg::ADDR_PRIO, 16'h0060, 16'h0020);
    rd_chk("normal kept", adc_seq_pkg::ADDR_MODE, 16'h00c0, 16'h0040);
    count_to(1'h1, n);
    rd_chk("prio result", adc_seq_pkg::ADDR_RESP, 16'h0fff, 16'h066d);
    rd_chk("prio flags", adc_seq_pkg::ADDR_PRIO, 16'h0060, 16'h0040);
    count_to(1'h0, n);
    check("start count", 16'h0006, 16'(starts.size()));
    for (int i = 0; i < 6 && starts.size() == 6; i++) check("start chan", 16'(prio_seq[i]), 16'(starts[i]));
    slow <= 1'h0;
    wr_reg(adc_seq_pkg::ADDR_MODE, 16'h0005);
    wr_reg(adc_seq_pkg::ADDR_RESET, 16'h0001);
    rd_chk("soft reset", adc_seq_pkg::ADDR_MODE, 16'h0040, 16'h0000);
    wr_reg(adc_seq_pkg::ADDR_MODE, 16'h0001);
    count_to(1'h0, n);
    check("restart", 16'h0001, 16'(n));
    wr_reg(adc_seq_pkg::ADDR_MODE, 16'h0000);
    wr_reg(adc_seq_pkg::ADDR_CHAN, 16'h0005);
    wr_reg(adc_seq_pkg::ADDR_TRIG, 16'h0005);
    trig(1, 1'h0, 1'h0, 4'h5);
    trig(2, 1'h1, 1'h0, 4'h9);
    wr_reg(adc_seq_pkg::ADDR_TRIG, 16'h000f);
    trig(1, 1'h0, 1'h1, 4'h5);
    trig(2, 1'h1, 1'h1, 4'h9);
    wr_reg(adc_seq_pkg::ADDR_TRIG, 16'h0006);
    trig(0, 1'h0, 1'h1, 4'h5);
    wr_reg(adc_seq_pkg::ADDR_TRIG, 16'h0009);
    trig(0, 1'h1, 1'h1, 4'h9);
    tally_and_finish;
  end
endmodule
